/* core/prm_pkg.sv */
// constants for the peripheral pin remap matrix: pin codes, signal slots,
// select field positions and select codes.
// assumes pins are flattened as port*16+bit, ports A..E in order.
// Function
// - select bit feeds oscillator into timer5 ch4
// - timer4 channels on PB6-PB9 or PD12-PD15
// - timer3 default: PA6, PA7, PB0, PB1
// - timer3 partial: ch1/ch2 to PB4/PB5
// - timer3 full: ch1-ch4 to PC6-PC9
// - timer2 ch1 PA0/PA15, ch3-4 PA2-3/PB10-11
// - timer1 default pins, break PB12, complements PB13-15
// - timer1 partial moves break and complements only
// - timer1 full remap onto port E
// - serial3 on PB10-PB14 or PD8-PD12
// - serial3 partial: tx/rx/ck to PC10-PC12
// - serial2 on PA0-PA4 or PD3-PD7
// - serial1 on PA9/PA10 or PB6/PB7
// - i2c1 on PB6/PB7 or PB8/PB9
// - spi1 on PA4-PA7 or PA15,PB3-PB5
// - spi3 on PA15,PB3-PB5 or PA4,PC10-PC12
// - ethernet receive on PA7,PC4,PC5,PB0,PB1 or PD8-12
// - timer4 select is config bit 12
// - timer3 select is config bits 11:10
// - timer5 internal select is config bit 16

`default_nettype none

package prm_pkg;
    localparam int NUM_PINS = 80;
    localparam int NUM_SIGS = 49;
    localparam int CFG_W    = 32;

    typedef logic [6:0] prm_pin_t;

    // select field positions in the remap configuration word
    localparam int SEL_SPI1_BIT  = 0;
    localparam int SEL_I2C1_BIT  = 1;
    localparam int SEL_U1_BIT    = 2;
    localparam int SEL_U2_BIT    = 3;
    localparam int SEL_U3_LSB    = 4;
    localparam int SEL_T1_LSB    = 6;
    localparam int SEL_T2_LSB    = 8;
    localparam int SEL_T3_LSB    = 10;
    localparam int SEL_T4_BIT    = 12;
    localparam int SEL_T5_BIT    = 16;

    // two-bit select codes
    localparam logic [1:0] SEL_NONE   = 2'h0;
    localparam logic [1:0] SEL_PART_A = 2'h1;
    localparam logic [1:0] SEL_PART_B = 2'h2;
    localparam logic [1:0] SEL_FULL   = 2'h3;

    // peripheral signal slots
    localparam int SIG_T1_ETR = 0,  SIG_T1_CH1 = 1,  SIG_T1_BKIN = 5,  SIG_T1_CH1N = 6;
    localparam int SIG_T2_CH1 = 9,  SIG_T3_CH1 = 13, SIG_T4_CH1 = 17, SIG_T5_CH4 = 21;
    localparam int SIG_U1_TX  = 22, SIG_U2_CTS = 24, SIG_U3_TX = 29,  SIG_I2C_SCL = 34;
    localparam int SIG_SPI1   = 36, SIG_SPI3 = 40,   SIG_ETH = 44;

    // pin codes: port in bits 6:4, bit number in 3:0
    localparam prm_pin_t PIN_A0 = 7'h00, PIN_A1 = 7'h01, PIN_A2 = 7'h02, PIN_A3 = 7'h03;
    localparam prm_pin_t PIN_A4 = 7'h04, PIN_A5 = 7'h05, PIN_A6 = 7'h06, PIN_A7 = 7'h07;
    localparam prm_pin_t PIN_A8 = 7'h08, PIN_A9 = 7'h09, PIN_A10 = 7'h0a, PIN_A11 = 7'h0b;
    localparam prm_pin_t PIN_A12 = 7'h0c, PIN_A13 = 7'h0d, PIN_A15 = 7'h0f;
    localparam prm_pin_t PIN_B0 = 7'h10, PIN_B1 = 7'h11, PIN_B3 = 7'h13, PIN_B4 = 7'h14;
    localparam prm_pin_t PIN_B5 = 7'h15, PIN_B6 = 7'h16, PIN_B7 = 7'h17, PIN_B8 = 7'h18;
    localparam prm_pin_t PIN_B9 = 7'h19, PIN_B10 = 7'h1a, PIN_B11 = 7'h1b, PIN_B12 = 7'h1c;
    localparam prm_pin_t PIN_B13 = 7'h1d, PIN_B14 = 7'h1e, PIN_B15 = 7'h1f;
    localparam prm_pin_t PIN_C4 = 7'h24, PIN_C5 = 7'h25, PIN_C6 = 7'h26, PIN_C7 = 7'h27;
    localparam prm_pin_t PIN_C8 = 7'h28, PIN_C9 = 7'h29, PIN_C10 = 7'h2a, PIN_C11 = 7'h2b;
    localparam prm_pin_t PIN_C12 = 7'h2c;
    localparam prm_pin_t PIN_D3 = 7'h33, PIN_D4 = 7'h34, PIN_D5 = 7'h35, PIN_D6 = 7'h36;
    localparam prm_pin_t PIN_D7 = 7'h37, PIN_D8 = 7'h38, PIN_D9 = 7'h39, PIN_D10 = 7'h3a;
    localparam prm_pin_t PIN_D11 = 7'h3b, PIN_D12 = 7'h3c, PIN_D13 = 7'h3d, PIN_D14 = 7'h3e;
    localparam prm_pin_t PIN_D15 = 7'h3f;
    localparam prm_pin_t PIN_E7 = 7'h47, PIN_E8 = 7'h48, PIN_E9 = 7'h49, PIN_E10 = 7'h4a;
    localparam prm_pin_t PIN_E11 = 7'h4b, PIN_E12 = 7'h4c, PIN_E13 = 7'h4d, PIN_E14 = 7'h4e;
    localparam prm_pin_t PIN_E15 = 7'h4f;
endpackage

`default_nettype wire

/* core/prm_sync.sv */
// two-flop synchroniser for a vector of asynchronous levels.
// assumes each bit is an independent level; no bus coherence.

`default_nettype none

module prm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // first stage is read only by the second stage
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

`default_nettype wire

/* core/prm_pin_drive.sv */
// per-pin output arbiter: finds which peripheral signal owns each pin.
// assumes sig_pin holds the selected pin of every signal; lower slot wins.

`default_nettype none

module prm_pin_drive
    import prm_pkg::*;
(
    input  wire prm_pin_t          sig_pin [NUM_SIGS],
    input  wire logic [NUM_SIGS-1:0] sig_out,
    input  wire logic [NUM_SIGS-1:0] sig_oe,
    output logic      [NUM_PINS-1:0] drive_val,
    output logic      [NUM_PINS-1:0] drive_en
);
    genvar p;
    generate
        for (p = 0; p < NUM_PINS; p++)
        begin : g_pin
            // scan high to low so the lowest slot overrides a clash
            // only selected pins
            always_comb
            begin
                drive_en[p]  = 1'b0;
                drive_val[p] = 1'b0;
                for (int s = NUM_SIGS - 1; s >= 0; s--)
                begin
                    if (sig_oe[s] && sig_pin[s] == prm_pin_t'(p))
                    begin
                        drive_en[p]  = 1'b1;
                        drive_val[p] = sig_out[s];
                    end
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

/* core/prm_matrix.sv */
// top of the peripheral pin remap matrix: select decode, pin routing,
// registered pin drive and registered peripheral input return.
// assumes peripherals and the config word share clk; pins and the
// oscillator are asynchronous and are synchronised here.

`default_nettype none

module prm_matrix
    import prm_pkg::*;
(
    input  wire logic [CFG_W-1:0]    remap_config,
    input  wire logic                spi3_pin_select,
    input  wire logic                eth_pin_select,
    input  wire logic                low_speed_internal_oscillator,
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic [NUM_PINS-1:0] pin_in,
    output logic      [NUM_PINS-1:0] pin_out,
    output logic      [NUM_PINS-1:0] pin_oe_n,
    input  wire logic [NUM_SIGS-1:0] periph_out,
    input  wire logic [NUM_SIGS-1:0] periph_oe,
    output logic      [NUM_SIGS-1:0] periph_in
);
    ////////////////////////////////////////////////////////////////////////////
    // select field decode

    logic       timer5_ch4_internal_select;
    logic       timer4_pin_select;
    logic [1:0] timer3_pin_select;
    logic [1:0] timer2_pin_select;
    logic [1:0] timer1_pin_select;
    logic [1:0] usart3_pin_select;
    logic       usart2_pin_select;
    logic       usart1_pin_select;
    logic       i2c1_pin_select;
    logic       spi1_pin_select;

    assign timer5_ch4_internal_select = remap_config[SEL_T5_BIT];
    assign timer4_pin_select = remap_config[SEL_T4_BIT];
    assign timer3_pin_select = remap_config[SEL_T3_LSB +: 2];
    assign timer2_pin_select = remap_config[SEL_T2_LSB +: 2];
    assign timer1_pin_select = remap_config[SEL_T1_LSB +: 2];
    assign usart3_pin_select = remap_config[SEL_U3_LSB +: 2];
    assign usart2_pin_select = remap_config[SEL_U2_BIT];
    assign usart1_pin_select = remap_config[SEL_U1_BIT];
    assign i2c1_pin_select   = remap_config[SEL_I2C1_BIT];
    assign spi1_pin_select   = remap_config[SEL_SPI1_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // pin selection per signal; unlisted codes fall to the default branch

    prm_pin_t sig_pin [NUM_SIGS];

    always_comb
    begin
        sig_pin[SIG_T1_ETR]      = PIN_A12;
        sig_pin[SIG_T1_CH1]      = PIN_A8;
        sig_pin[SIG_T1_CH1 + 1]  = PIN_A9;
        sig_pin[SIG_T1_CH1 + 2]  = PIN_A10;
        sig_pin[SIG_T1_CH1 + 3]  = PIN_A11;
        sig_pin[SIG_T1_BKIN]     = PIN_B12;
        sig_pin[SIG_T1_CH1N]     = PIN_B13;
        sig_pin[SIG_T1_CH1N + 1] = PIN_B14;
        sig_pin[SIG_T1_CH1N + 2] = PIN_B15;
        case (timer1_pin_select)
            SEL_PART_A:
            begin
                sig_pin[SIG_T1_BKIN]     = PIN_A6;
                sig_pin[SIG_T1_CH1N]     = PIN_A7;
                sig_pin[SIG_T1_CH1N + 1] = PIN_B0;
                sig_pin[SIG_T1_CH1N + 2] = PIN_B1;
            end
            SEL_FULL:
            begin
                sig_pin[SIG_T1_ETR]      = PIN_E7;
                sig_pin[SIG_T1_CH1]      = PIN_E9;
                sig_pin[SIG_T1_CH1 + 1]  = PIN_E11;
                sig_pin[SIG_T1_CH1 + 2]  = PIN_E13;
                sig_pin[SIG_T1_CH1 + 3]  = PIN_E14;
                sig_pin[SIG_T1_BKIN]     = PIN_E15;
                sig_pin[SIG_T1_CH1N]     = PIN_E8;
                sig_pin[SIG_T1_CH1N + 1] = PIN_E10;
                sig_pin[SIG_T1_CH1N + 2] = PIN_E12;
            end
            default:
            begin
            end
        endcase

        // timer2 split on two select bits
        // channel 1 and trigger share one slot and pin
        sig_pin[SIG_T2_CH1]     = timer2_pin_select[0] ? PIN_A15 : PIN_A0;
        sig_pin[SIG_T2_CH1 + 1] = timer2_pin_select[0] ? PIN_B3  : PIN_A1;
        sig_pin[SIG_T2_CH1 + 2] = timer2_pin_select[1] ? PIN_B10 : PIN_A2;
        sig_pin[SIG_T2_CH1 + 3] = timer2_pin_select[1] ? PIN_B11 : PIN_A3;

        sig_pin[SIG_T3_CH1]     = PIN_A6;
        sig_pin[SIG_T3_CH1 + 1] = PIN_A7;
        sig_pin[SIG_T3_CH1 + 2] = PIN_B0;
        sig_pin[SIG_T3_CH1 + 3] = PIN_B1;
        case (timer3_pin_select)
            SEL_PART_B:
            begin
                sig_pin[SIG_T3_CH1]     = PIN_B4;
                sig_pin[SIG_T3_CH1 + 1] = PIN_B5;
            end
            SEL_FULL:
            begin
                sig_pin[SIG_T3_CH1]     = PIN_C6;
                sig_pin[SIG_T3_CH1 + 1] = PIN_C7;
                sig_pin[SIG_T3_CH1 + 2] = PIN_C8;
                sig_pin[SIG_T3_CH1 + 3] = PIN_C9;
            end
            default:
            begin
            end
        endcase

        sig_pin[SIG_T4_CH1]     = timer4_pin_select ? PIN_D12 : PIN_B6;
        sig_pin[SIG_T4_CH1 + 1] = timer4_pin_select ? PIN_D13 : PIN_B7;
        sig_pin[SIG_T4_CH1 + 2] = timer4_pin_select ? PIN_D14 : PIN_B8;
        sig_pin[SIG_T4_CH1 + 3] = timer4_pin_select ? PIN_D15 : PIN_B9;

        // internal route is handled on the input side
        sig_pin[SIG_T5_CH4] = PIN_A3;

        sig_pin[SIG_U1_TX]     = usart1_pin_select ? PIN_B6 : PIN_A9;
        sig_pin[SIG_U1_TX + 1] = usart1_pin_select ? PIN_B7 : PIN_A10;

        sig_pin[SIG_U2_CTS]     = usart2_pin_select ? PIN_D3 : PIN_A0;
        sig_pin[SIG_U2_CTS + 1] = usart2_pin_select ? PIN_D4 : PIN_A1;
        sig_pin[SIG_U2_CTS + 2] = usart2_pin_select ? PIN_D5 : PIN_A2;
        sig_pin[SIG_U2_CTS + 3] = usart2_pin_select ? PIN_D6 : PIN_A3;
        sig_pin[SIG_U2_CTS + 4] = usart2_pin_select ? PIN_D7 : PIN_A4;

        sig_pin[SIG_U3_TX]     = PIN_B10;
        sig_pin[SIG_U3_TX + 1] = PIN_B11;
        sig_pin[SIG_U3_TX + 2] = PIN_B12;
        sig_pin[SIG_U3_TX + 3] = PIN_B13;
        sig_pin[SIG_U3_TX + 4] = PIN_B14;
        case (usart3_pin_select)
            SEL_PART_A:
            begin
                // tx, rx, ck to port C
                sig_pin[SIG_U3_TX]     = PIN_C10;
                sig_pin[SIG_U3_TX + 1] = PIN_C11;
                sig_pin[SIG_U3_TX + 2] = PIN_C12;
            end
            SEL_FULL:
            begin
                sig_pin[SIG_U3_TX]     = PIN_D8;
                sig_pin[SIG_U3_TX + 1] = PIN_D9;
                sig_pin[SIG_U3_TX + 2] = PIN_D10;
                sig_pin[SIG_U3_TX + 3] = PIN_D11;
                sig_pin[SIG_U3_TX + 4] = PIN_D12;
            end
            default:
            begin
            end
        endcase

        sig_pin[SIG_I2C_SCL]     = i2c1_pin_select ? PIN_B8 : PIN_B6;
        sig_pin[SIG_I2C_SCL + 1] = i2c1_pin_select ? PIN_B9 : PIN_B7;

        sig_pin[SIG_SPI1]     = spi1_pin_select ? PIN_A15 : PIN_A4;
        sig_pin[SIG_SPI1 + 1] = spi1_pin_select ? PIN_B3  : PIN_A5;
        sig_pin[SIG_SPI1 + 2] = spi1_pin_select ? PIN_B4  : PIN_A6;
        sig_pin[SIG_SPI1 + 3] = spi1_pin_select ? PIN_B5  : PIN_A7;

        sig_pin[SIG_SPI3]     = spi3_pin_select ? PIN_A4  : PIN_A15;
        sig_pin[SIG_SPI3 + 1] = spi3_pin_select ? PIN_C10 : PIN_B3;
        sig_pin[SIG_SPI3 + 2] = spi3_pin_select ? PIN_C11 : PIN_B4;
        sig_pin[SIG_SPI3 + 3] = spi3_pin_select ? PIN_C12 : PIN_B5;

        sig_pin[SIG_ETH]     = eth_pin_select ? PIN_D8  : PIN_A7;
        sig_pin[SIG_ETH + 1] = eth_pin_select ? PIN_D9  : PIN_C4;
        sig_pin[SIG_ETH + 2] = eth_pin_select ? PIN_D10 : PIN_C5;
        sig_pin[SIG_ETH + 3] = eth_pin_select ? PIN_D11 : PIN_B0;
        sig_pin[SIG_ETH + 4] = eth_pin_select ? PIN_D12 : PIN_B1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // output side: arbitrate and register

    logic [NUM_SIGS-1:0] sig_oe_eff;
    logic [NUM_PINS-1:0] drive_val;
    logic [NUM_PINS-1:0] drive_en;

    // an internally routed channel must not also drive its pin
    // internal route releases pin
    always_comb
    begin
        sig_oe_eff             = periph_oe;
        sig_oe_eff[SIG_T5_CH4] = periph_oe[SIG_T5_CH4] & ~timer5_ch4_internal_select;
    end

    prm_pin_drive u_drive (
        .sig_pin   (sig_pin),
        .sig_out   (periph_out),
        .sig_oe    (sig_oe_eff),
        .drive_val (drive_val),
        .drive_en  (drive_en)
    );

    // pins released (oe_n high) through reset
    // drive only owned pins
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pin_out  <= '0;
            pin_oe_n <= '1;
        end
        else
        begin
            pin_out  <= drive_val;
            pin_oe_n <= ~drive_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input side: synchronise pins and oscillator, pick selected pin

    logic [NUM_PINS-1:0] pin_sync;
    logic                osc_sync;

    prm_sync #(.W(NUM_PINS)) u_pin_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // oscillator is slow, so a level synchroniser keeps its edges usable
    prm_sync #(.W(1)) u_osc_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in (low_speed_internal_oscillator),
        .sync_out (osc_sync)
    );

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            periph_in <= '0;
        end
        else
        begin
            for (int s = 0; s < NUM_SIGS; s++)
            begin
                periph_in[s] <= pin_sync[sig_pin[s]];
            end
            if (timer5_ch4_internal_select)
            begin
                periph_in[SIG_T5_CH4] <= osc_sync;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    AST_T5_INTERNAL: assert property (@(posedge clk) disable iff (srst)
        timer5_ch4_internal_select |=> periph_in[SIG_T5_CH4] == $past(osc_sync))
        else $error("timer5 ch4 does not see the oscillator");

    AST_T4_REMAP: assert property (@(posedge clk) disable iff (srst)
        (timer4_pin_select && periph_oe[SIG_T4_CH1])
        |=> !pin_oe_n[PIN_D12] && pin_out[PIN_D12] == $past(periph_out[SIG_T4_CH1]))
        else $error("timer4 ch1 not driven on PD12");

    AST_T3_DEFAULT_IN: assert property (@(posedge clk) disable iff (srst)
        (timer3_pin_select == SEL_NONE) |=> periph_in[SIG_T3_CH1] == $past(pin_sync[PIN_A6]))
        else $error("timer3 ch1 not sampled from PA6");

    AST_T3_PARTIAL: assert property (@(posedge clk) disable iff (srst)
        (timer3_pin_select == SEL_PART_B && periph_oe[SIG_T3_CH1 + 1])
        |=> !pin_oe_n[PIN_B5] && pin_out[PIN_B5] == $past(periph_out[SIG_T3_CH1 + 1]))
        else $error("timer3 ch2 not driven on PB5");

    AST_T3_FULL: assert property (@(posedge clk) disable iff (srst)
        (timer3_pin_select == SEL_FULL) |-> sig_pin[SIG_T3_CH1 + 2] == PIN_C8)
        else $error("timer3 ch3 not on PC8");

    AST_T2_CH1: assert property (@(posedge clk) disable iff (srst)
        timer2_pin_select[0] |=> periph_in[SIG_T2_CH1] == $past(pin_sync[PIN_A15]))
        else $error("timer2 ch1 not sampled from PA15");

    AST_T1_PARTIAL: assert property (@(posedge clk) disable iff (srst)
        (timer1_pin_select == SEL_PART_A)
        |-> sig_pin[SIG_T1_BKIN] == PIN_A6 && sig_pin[SIG_T1_CH1] == PIN_A8)
        else $error("timer1 partial remap wrong");

    AST_T1_FULL_BKIN: assert property (@(posedge clk) disable iff (srst)
        (timer1_pin_select == SEL_FULL) |=> periph_in[SIG_T1_BKIN] == $past(pin_sync[PIN_E15]))
        else $error("timer1 break not sampled from PE15");

    AST_UNUSED_CODE: assert property (@(posedge clk) disable iff (srst)
        (usart3_pin_select == SEL_PART_B) |-> sig_pin[SIG_U3_TX] == PIN_B10)
        else $error("serial3 code 10 not treated as no remap");

    AST_U3_PARTIAL: assert property (@(posedge clk) disable iff (srst)
        (usart3_pin_select == SEL_PART_A)
        |-> sig_pin[SIG_U3_TX] == PIN_C10 && sig_pin[SIG_U3_TX + 3] == PIN_B13)
        else $error("serial3 partial remap wrong");

    AST_ETH_IN: assert property (@(posedge clk) disable iff (srst)
        eth_pin_select |=> periph_in[SIG_ETH] == $past(pin_sync[PIN_D8]))
        else $error("ethernet rx valid not sampled from PD8");

    AST_IDLE_PIN: assert property (@(posedge clk) disable iff (srst)
        ##1 pin_oe_n[PIN_A13])
        else $error("unrouted pin is driven");
endmodule

`default_nettype wire

/* testbench/prm_pad_model.sv */
// pad model: the port pins as seen from outside the remap matrix.
// assumes pin_oe_n low means the matrix drives that pin.

`default_nettype none

module prm_pad_model
    import prm_pkg::*;
(
    input  wire logic [NUM_PINS-1:0] pin_out,
    input  wire logic [NUM_PINS-1:0] pin_oe_n,
    input  wire logic [NUM_PINS-1:0] ext_level,
    output logic      [NUM_PINS-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    // a driven pad reads back the matrix, a released one the outside world;
    // the bench keeps released pins opposite to the expected level so a
    // wrong route shows up instead of matching by luck
    assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule

`default_nettype wire

/* testbench/test_prm_matrix.sv */
// self-checking bench for the pin remap matrix: one signal routed per case.
// assumes prm_pad_model closes the pin loop; oscillator code 7'h7f marks timer5 internal.

`default_nettype none

module test_prm_matrix
    import prm_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [31:0] cfg; logic s3; logic eth; int slot; prm_pin_t pin;} prm_case_t;
    typedef struct {int due; int slot; prm_pin_t pin; logic v; logic rst;} prm_note_t;

    logic                clk;
    logic                srst;
    logic                s3;
    logic                eth;
    logic                osc;
    logic [CFG_W-1:0]    cfg;
    logic [NUM_PINS-1:0] ext;
    logic [NUM_PINS-1:0] pin_in;
    logic [NUM_PINS-1:0] pin_out;
    logic [NUM_PINS-1:0] pin_oe_n;
    logic [NUM_PINS-1:0] sel_mask;
    logic [NUM_SIGS-1:0] p_out;
    logic [NUM_SIGS-1:0] p_oe;
    logic [NUM_SIGS-1:0] p_in;
    prm_note_t           notes [$];
    prm_note_t           n;
    int                  cyc = 0;
    int                  fails = 0;
    int                  tests_run = 0;
    int                  seed = 43813;

    // one row per route: config word, spi3 select, eth select, slot, pin
    prm_case_t cases [42] = '{
        '{32'h0000_0000, 0, 0, 17, PIN_B6}, '{32'h0000_1000, 0, 0, 20, PIN_D15},
        '{32'h0000_1000, 0, 0, 17, PIN_D12},
        '{32'h0000_0000, 0, 0, 13, PIN_A6}, '{32'h0000_0000, 0, 0, 16, PIN_B1},
        '{32'h0000_0800, 0, 0, 13, PIN_B4}, '{32'h0000_0800, 0, 0, 16, PIN_B1},
        '{32'h0000_0800, 0, 0, 14, PIN_B5},
        '{32'h0000_0c00, 0, 0, 15, PIN_C8}, '{32'h0000_0400, 0, 0, 14, PIN_A7},
        '{32'h0000_0000, 0, 0, 9, PIN_A0}, '{32'h0000_0100, 0, 0, 9, PIN_A15},
        '{32'h0000_0200, 0, 0, 11, PIN_B10}, '{32'h0000_0300, 0, 0, 12, PIN_B11},
        '{32'h0000_0000, 0, 0, 0, PIN_A12}, '{32'h0000_0000, 0, 0, 5, PIN_B12},
        '{32'h0000_0040, 0, 0, 5, PIN_A6}, '{32'h0000_0040, 0, 0, 8, PIN_B1},
        '{32'h0000_0040, 0, 0, 4, PIN_A11},
        '{32'h0000_00c0, 0, 0, 0, PIN_E7}, '{32'h0000_00c0, 0, 0, 5, PIN_E15},
        '{32'h0000_00c0, 0, 0, 6, PIN_E8}, '{32'h0000_0080, 0, 0, 6, PIN_B13},
        '{32'h0000_0000, 0, 0, 29, PIN_B10}, '{32'h0000_0030, 0, 0, 33, PIN_D12},
        '{32'h0000_0010, 0, 0, 31, PIN_C12}, '{32'h0000_0010, 0, 0, 32, PIN_B13},
        '{32'h0000_0020, 0, 0, 29, PIN_B10},
        '{32'h0000_0000, 0, 0, 24, PIN_A0}, '{32'h0000_0008, 0, 0, 28, PIN_D7},
        '{32'h0000_0000, 0, 0, 22, PIN_A9}, '{32'h0000_0004, 0, 0, 23, PIN_B7},
        '{32'h0000_0000, 0, 0, 34, PIN_B6}, '{32'h0000_0002, 0, 0, 35, PIN_B9},
        '{32'h0000_0000, 0, 0, 36, PIN_A4}, '{32'h0000_0001, 0, 0, 37, PIN_B3},
        '{32'h0000_0000, 0, 0, 40, PIN_A15}, '{32'h0000_0000, 1, 0, 43, PIN_C12},
        '{32'h0000_0000, 0, 0, 44, PIN_A7}, '{32'h0000_0000, 0, 1, 48, PIN_D12},
        '{32'h0001_0000, 0, 0, 21, 7'h7f}, '{32'h0000_0000, 0, 0, 21, PIN_A3}
    };

    prm_matrix DUT (
        .remap_config                  (cfg),
        .spi3_pin_select               (s3),
        .eth_pin_select                (eth),
        .low_speed_internal_oscillator (osc),
        .clk                           (clk),
        .srst                          (srst),
        .pin_in                        (pin_in),
        .pin_out                       (pin_out),
        .pin_oe_n                      (pin_oe_n),
        .periph_out                    (p_out),
        .periph_oe                     (p_oe),
        .periph_in                     (p_in)
    );

    prm_pad_model pads (
        .pin_out   (pin_out),
        .pin_oe_n  (pin_oe_n),
        .ext_level (ext),
        .pin_in    (pin_in)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock and cycle count
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) cyc <= cyc + 1;

    task automatic check(input logic [NUM_PINS-1:0] seen, input logic [NUM_PINS-1:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (fails == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // monitor: takes due notes off the queue at the falling edge, outputs settled
    always @(negedge clk)
    begin
        while (notes.size() > 0 && notes[0].due <= cyc)
        begin
            n = notes.pop_front();
            sel_mask = '0;
            if (n.rst)
            begin
                check(pin_oe_n, '1);
                check(NUM_PINS'(p_in), '0);
            end
            else if (n.pin == 7'h7f)
            begin
                check(pin_oe_n, '1);
                check(NUM_PINS'(p_in[SIG_T5_CH4]), NUM_PINS'(n.v));
            end
            else
            begin
                sel_mask[n.pin] = 1'b1;
                check(pin_oe_n, ~sel_mask);
                check(NUM_PINS'(pin_out[n.pin]), NUM_PINS'(n.v));
                check(NUM_PINS'(p_in[n.slot]), NUM_PINS'(n.v));
            end
        end
    end

    // driver: one routed signal per case, released pins held at the inverse
    task automatic run_case(input prm_case_t c);
        logic v;
        @(negedge clk);
        v = 1'($random(seed));
        cfg = c.cfg;
        s3 = c.s3;
        eth = c.eth;
        osc = v;
        ext = {NUM_PINS{~v}};
        if (c.pin != 7'h7f)
            ext[c.pin] = v;
        p_out = {NUM_SIGS{~v}};
        p_out[c.slot] = v;
        p_oe = '0;
        p_oe[c.slot] = 1'b1;
        // five edges cover the three-flop input path after a select change
        notes.push_back('{cyc + 5, c.slot, c.pin, v, 1'b0});
        repeat (5) @(negedge clk);
    endtask

    initial
    begin
        srst = 1'b1;
        cfg = '0;
        s3 = 1'b0;
        eth = 1'b0;
        osc = 1'b0;
        ext = '0;
        p_out = '0;
        p_oe = '0;
        repeat (16) @(negedge clk);
        notes.push_back('{cyc, 0, 7'h00, 1'b0, 1'b1});
        srst = 1'b0;
        for (int r = 0; r < 2; r++)
            foreach (cases[i])
                run_case(cases[i]);
        // second reset while a signal still requests its pin
        @(negedge clk);
        srst = 1'b1;
        notes.push_back('{cyc + 2, 0, 7'h00, 1'b0, 1'b1});
        repeat (3) @(negedge clk);
        srst = 1'b0;
        for (int k = 0; k < 20 && notes.size() > 0; k++)
            @(negedge clk);
        if (notes.size() > 0)
            fails++;
        summarize();
    end
endmodule

`default_nettype wire
